// File: hw/hub_status_reporting.sv
// Purpose: hub controller state, endpoint 0/1 answers, power, indicator
// Assumes: serial engine delivers decoded tokens and requests
// Notes: open-drain pins drive low only; pull-ups are external
`timescale 1ns/1ps
// How it works
// RULE1: reset clears every controller state bit to zero.
// RULE2: state bit 0 follows the value written by set configuration.
// RULE3: state bit 1 is remote wakeup, set and cleared by feature requests.
// RULE4: state bits 2 and 3 flag endpoint 0 and endpoint 1 stalled.
// RULE5: endpoint 0 takes standard and hub class control requests.
// RULE6: endpoint 0 selects device, config, interface, endpoint, hub descriptors.
// RULE7: an endpoint descriptor for endpoint 0 is refused with a stall.
// RULE8: endpoint 1 carries the change bitmap in interrupt transfers.
// RULE9: pending changes are sampled into the bitmap at the EOF2 marker.
// RULE10: bit 0 hub change, bits 1-4 ports, bits 5-7 read zero.
// RULE11: an IN to endpoint 1 with an empty bitmap gets NAK.
// RULE12: with any bit 0-4 set, the whole bitmap byte is sent.
// RULE13: a change keeps being reported until the host clears it.
// RULE14: nothing is reported on endpoint 1 before configuration.
// RULE15: once configured the indicator pin is driven low steadily.
// RULE16: overcurrent blinks the indicator until power off or reconfiguration.
// RULE17: the oscillator is stopped while suspended.
// RULE18: clocks come from a 6 MHz reference multiplied by the PLL.
// RULE19: low overcurrent input sets indicator, change bit, drops port power.
// RULE20: frame timer runs at 12 MHz bit rate, restarted on start of frame.
// RULE21: indicator blink toggles every quarter second from the frame timer.
module hub_status_reporting
   import hub_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // tokens from the serial engine
   input wire logic SOF_TOKEN,
   input wire logic IN_TOKEN,
   input wire logic [3:0] TOKEN_EP,
   // decoded control requests
   input wire logic REQ_VALID,
   input wire hub_pkg::req_e REQ_CODE,
   input wire logic [7:0] REQ_VALUE,
   input wire logic [7:0] REQ_INDEX,
   // control answers
   output logic CTRL_ACK,
   output logic CTRL_STALL,
   output hub_pkg::desc_sel_e DESC_SEL,
   // interrupt endpoint answers
   output logic EP1_NAK,
   output logic EP1_STALL,
   output logic EP1_DATA_VALID,
   output logic [7:0] EP1_DATA,
   // port change events from the repeater
   input wire logic [hub_pkg::NUM_PORTS-1:0] PORT_CHANGE,
   // overcurrent, port power, indicator pins
   input wire logic OVERCURRENT_SENSE_INPUT_N,
   output logic PORT_POWER_ENABLE_O,
   output logic PORT_POWER_ENABLE_OE,
   output logic STATUS_LED_O,
   output logic STATUS_LED_OE,
   // clock control
   input wire logic SUSPEND,
   output logic OSC_RUN,
   output logic PLL_RUN,
   // register views
   output logic [3:0] HUB_CONTROLLER_STATE,
   output logic [7:0] CHANGE_BITMAP,
   output logic OVERCURRENT_STATUS
);
   localparam int PLL_HZ = REF_HZ * PLL_MULT;

   frame_if frm ();

   logic [3:0] state_reg;
   logic [NUM_PORTS:0] pending_reg;
   logic [NUM_PORTS:0] pending_next;
   logic [NUM_PORTS:0] pending_set;
   logic [NUM_PORTS:0] pending_clr;
   logic [7:0] bitmap_reg;
   logic [1:0] ovc_sync_reg;
   logic ovc_prev_reg;
   logic oc_status_reg;
   logic oc_blink_reg;
   logic power_reg;
   logic led_reg;
   logic osc_run_reg;
   logic ctrl_ack_reg;
   logic ctrl_stall_reg;
   desc_sel_e desc_sel_reg;
   desc_sel_e desc_sel_next;
   logic desc_bad;
   logic ep1_nak_reg;
   logic ep1_stall_reg;
   logic ep1_valid_reg;
   logic [7:0] ep1_data_reg;
   logic oc_active;
   logic oc_rise;
   logic cfg_req;
   logic pwr_off_req;

   hub_frame_timer u_timer
   (
      .CLK(CLK),
      .RST(RST),
      .frm(frm.timer)
   );

   assign frm.sof = SOF_TOKEN;

   // ----------------------------------------------------------------
   // overcurrent input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ovc_sync_reg <= 2'h3;
         ovc_prev_reg <= 1'b0;
      end
      else
      begin
         ovc_sync_reg <= {ovc_sync_reg[0], OVERCURRENT_SENSE_INPUT_N};
         ovc_prev_reg <= oc_active;
      end
   end

   assign oc_active = !ovc_sync_reg[1];
   assign oc_rise = oc_active && !ovc_prev_reg;
   assign cfg_req = REQ_VALID && REQ_CODE == REQ_SET_CONFIG;
   assign pwr_off_req = REQ_VALID && REQ_CODE == REQ_CLR_PORT_POWER;

   // ----------------------------------------------------------------
   // controller state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
         state_reg <= STATE_RESET; // RULE1
      else if (REQ_VALID)
      begin
         // each new request on endpoint 0 clears its stall unless that request is itself stalled
         state_reg[ST_EP0_STALL] <= desc_bad ||
                                    REQ_CODE == REQ_OTHER; // RULE4
         if (REQ_CODE == REQ_SET_CONFIG)
            state_reg[ST_CONFIGURED] <= REQ_VALUE != 8'h00; // RULE2
         else if (REQ_CODE == REQ_SET_WAKEUP)
            state_reg[ST_WAKEUP] <= 1'b1; // RULE3
         else if (REQ_CODE == REQ_CLR_WAKEUP)
            state_reg[ST_WAKEUP] <= 1'b0; // RULE3
         else if (REQ_CODE == REQ_SET_EP_HALT &&
                  REQ_INDEX[3:0] == EP_STATUS)
            state_reg[ST_EP1_STALL] <= 1'b1; // RULE4
         else if (REQ_CODE == REQ_CLR_EP_HALT &&
                  REQ_INDEX[3:0] == EP_STATUS)
            state_reg[ST_EP1_STALL] <= 1'b0; // RULE4
      end
   end

   // ----------------------------------------------------------------
   // descriptor selection on endpoint 0
   // ----------------------------------------------------------------
   always_comb
   begin
      desc_sel_next = DSEL_NONE;
      desc_bad = 1'b0;
      if (REQ_CODE == REQ_GET_DESC)
      begin
         if (REQ_VALUE == DT_DEVICE)
            desc_sel_next = DSEL_DEVICE; // RULE6
         else if (REQ_VALUE == DT_CONFIG)
            desc_sel_next = DSEL_CONFIG; // RULE6
         else if (REQ_VALUE == DT_INTERFACE)
            desc_sel_next = DSEL_INTERFACE; // RULE6
         else if (REQ_VALUE == DT_ENDPOINT &&
                  REQ_INDEX[3:0] == EP_STATUS)
            desc_sel_next = DSEL_ENDPOINT; // RULE6
         else if (REQ_VALUE == DT_HUB)
            desc_sel_next = DSEL_HUB; // RULE6
         else
            desc_bad = 1'b1; // RULE7
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ctrl_ack_reg <= 1'b0;
         ctrl_stall_reg <= 1'b0;
         desc_sel_reg <= DSEL_NONE;
      end
      else
      begin
         ctrl_ack_reg <= REQ_VALID && !desc_bad &&
                         REQ_CODE != REQ_OTHER; // RULE5
         ctrl_stall_reg <= REQ_VALID &&
                           (desc_bad || REQ_CODE == REQ_OTHER); // RULE5
         if (REQ_VALID)
            desc_sel_reg <= desc_sel_next;
      end
   end

   // ----------------------------------------------------------------
   // pending changes, set wins over clear
   // ----------------------------------------------------------------
   always_comb
   begin
      pending_set = {PORT_CHANGE, oc_rise}; // RULE19
      pending_clr = '0;
      if (REQ_VALID && REQ_CODE == REQ_CLR_PORT_CHANGE &&
          REQ_INDEX >= 8'h01 && REQ_INDEX <= 8'(NUM_PORTS))
         pending_clr[REQ_INDEX[2:0]] = 1'b1; // RULE13
      if (REQ_VALID && REQ_CODE == REQ_CLR_HUB_CHANGE)
         pending_clr[CHG_HUB] = 1'b1; // RULE13
      pending_next = (pending_reg & ~pending_clr) | pending_set; // RULE13
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         pending_reg <= '0;
      else
         pending_reg <= pending_next;
   end

   // ----------------------------------------------------------------
   // change bitmap sampled at EOF2
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST || !state_reg[ST_CONFIGURED])
         bitmap_reg <= BITMAP_RESET; // RULE14
      else if (frm.eof2)
         bitmap_reg <= {CHG_RESERVED, pending_next}; // RULE9 RULE10
      else
         bitmap_reg <= {CHG_RESERVED,
                        bitmap_reg[NUM_PORTS:0] & ~pending_clr}; // RULE13
   end

   // ----------------------------------------------------------------
   // interrupt endpoint answers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ep1_nak_reg <= 1'b0;
         ep1_stall_reg <= 1'b0;
         ep1_valid_reg <= 1'b0;
         ep1_data_reg <= 8'h00;
      end
      else
      begin
         ep1_nak_reg <= 1'b0;
         ep1_stall_reg <= 1'b0;
         ep1_valid_reg <= 1'b0;
         if (IN_TOKEN && TOKEN_EP == EP_STATUS)
         begin
            if (state_reg[ST_EP1_STALL])
               ep1_stall_reg <= 1'b1; // RULE4
            else if (bitmap_reg[NUM_PORTS:0] == '0)
               ep1_nak_reg <= 1'b1; // RULE11 RULE14
            else
            begin
               ep1_valid_reg <= 1'b1; // RULE8 RULE12
               ep1_data_reg <= bitmap_reg; // RULE12
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // overcurrent, port power and indicator
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         oc_status_reg <= 1'b0;
         power_reg <= 1'b0;
      end
      else
      begin
         oc_status_reg <= oc_active; // RULE19
         if (oc_active)
            power_reg <= 1'b0; // RULE19
         else if (pwr_off_req)
            power_reg <= 1'b0;
         else if (REQ_VALID && REQ_CODE == REQ_SET_PORT_POWER)
            power_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         oc_blink_reg <= 1'b0;
      else if (oc_active)
         oc_blink_reg <= 1'b1; // RULE16
      else if (pwr_off_req || cfg_req)
         oc_blink_reg <= 1'b0; // RULE16
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         led_reg <= 1'b0;
      else if (oc_blink_reg)
         led_reg <= frm.blink; // RULE16 RULE21
      else
         led_reg <= state_reg[ST_CONFIGURED]; // RULE15
   end

   // ----------------------------------------------------------------
   // oscillator and PLL run control
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
         osc_run_reg <= 1'b1;
      else
         osc_run_reg <= !SUSPEND; // RULE17 RULE18
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign CTRL_ACK = ctrl_ack_reg;
   assign CTRL_STALL = ctrl_stall_reg;
   assign DESC_SEL = desc_sel_reg;
   assign EP1_NAK = ep1_nak_reg;
   assign EP1_STALL = ep1_stall_reg;
   assign EP1_DATA_VALID = ep1_valid_reg;
   assign EP1_DATA = ep1_data_reg;
   assign PORT_POWER_ENABLE_O = 1'b0;
   assign PORT_POWER_ENABLE_OE = !power_reg;
   assign STATUS_LED_O = 1'b0;
   assign STATUS_LED_OE = led_reg;
   assign OSC_RUN = osc_run_reg;
   assign PLL_RUN = osc_run_reg && PLL_HZ > 0;
   assign HUB_CONTROLLER_STATE = state_reg;
   assign CHANGE_BITMAP = bitmap_reg;
   assign OVERCURRENT_STATUS = oc_status_reg;
endmodule // hub_status_reporting

// File: hw/hub_pkg.sv
// Purpose: shared constants and types of the hub status reporting logic
// Assumes: 20 MHz system clock, full-speed 12 Mb/s upstream link
// Notes: descriptor contents live outside this logic
package hub_pkg;
   // ----------------------------------------------------------------
   // clocking and frame timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int BIT_HZ = 12000000;
   localparam int REF_HZ = 6000000;
   localparam int PLL_MULT = 8;
   localparam int FRAME_BITS = 12000;
   localparam int EOF2_BIT = 11990;
   localparam int BLINK_MS = 250;
   localparam int BLINK_FRAMES = BLINK_MS;
   localparam logic [4:0] ACC_STEP = 5'(BIT_HZ / 1000000);
   localparam logic [4:0] ACC_MOD = 5'(CLK_HZ / 1000000);

   // ----------------------------------------------------------------
   // controller state field positions and reset values
   // ----------------------------------------------------------------
   localparam int ST_CONFIGURED = 0;
   localparam int ST_WAKEUP = 1;
   localparam int ST_EP0_STALL = 2;
   localparam int ST_EP1_STALL = 3;
   localparam logic [3:0] STATE_RESET = 4'h0;

   // ----------------------------------------------------------------
   // change bitmap layout
   // ----------------------------------------------------------------
   localparam int CHG_HUB = 0;
   localparam int CHG_PORT1 = 1;
   localparam int NUM_PORTS = 4;
   localparam logic [2:0] CHG_RESERVED = 3'h0;
   localparam logic [7:0] BITMAP_RESET = 8'h00;

   // ----------------------------------------------------------------
   // descriptor type codes and endpoints
   // ----------------------------------------------------------------
   localparam logic [7:0] DT_DEVICE = 8'h01;
   localparam logic [7:0] DT_CONFIG = 8'h02;
   localparam logic [7:0] DT_INTERFACE = 8'h04;
   localparam logic [7:0] DT_ENDPOINT = 8'h05;
   localparam logic [7:0] DT_HUB = 8'h29;
   localparam logic [3:0] EP_CTRL = 4'h0;
   localparam logic [3:0] EP_STATUS = 4'h1;

   // decoded control requests from the serial engine
   typedef enum logic [3:0] {
      REQ_SET_CONFIG,
      REQ_SET_WAKEUP,
      REQ_CLR_WAKEUP,
      REQ_SET_EP_HALT,
      REQ_CLR_EP_HALT,
      REQ_SET_PORT_POWER,
      REQ_CLR_PORT_POWER,
      REQ_CLR_PORT_CHANGE,
      REQ_CLR_HUB_CHANGE,
      REQ_GET_DESC,
      REQ_OTHER
   } req_e;

   typedef enum logic [2:0] {
      DSEL_NONE,
      DSEL_DEVICE,
      DSEL_CONFIG,
      DSEL_INTERFACE,
      DSEL_ENDPOINT,
      DSEL_HUB
   } desc_sel_e;
endpackage

// File: hw/frame_if.sv
// Purpose: frame timing signals between controller and frame timer
// Assumes: one clock domain
// Notes: sof and eof2 are one-cycle pulses
`timescale 1ns/1ps
interface frame_if;
   logic sof;
   logic eof2;
   logic blink;
   modport timer (input sof, output eof2, output blink);
   modport ctrl (output sof, input eof2, input blink);
endinterface

// File: hw/hub_frame_timer.sv
// Purpose: full-speed frame timer with end-of-frame marker and blink
// Assumes: system clock faster than the bit rate
// Notes: bit ticks come from a fractional accumulator
`timescale 1ns/1ps
module hub_frame_timer
   import hub_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_BITS,
   parameter int EOF2_AT = EOF2_BIT,
   parameter int BLINK_LEN = BLINK_FRAMES
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // frame signals
   frame_if.timer frm
);
   logic [4:0] acc_reg;
   logic [13:0] bit_cnt_reg;
   logic [8:0] blink_cnt_reg;
   logic blink_reg;
   logic eof2_reg;
   logic [5:0] acc_sum;
   logic bit_tick;
   logic frame_end;
   logic eof2_hit;

   assign acc_sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};
   assign bit_tick = acc_sum >= {1'b0, ACC_MOD};
   assign frame_end = bit_tick && bit_cnt_reg == 14'(FRAME_LEN - 1);
   assign eof2_hit = bit_tick && !frm.sof &&
                     bit_cnt_reg == 14'(EOF2_AT); // RULE9

   // ----------------------------------------------------------------
   // 12 MHz bit tick
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
         acc_reg <= 5'h00;
      else if (bit_tick)
         acc_reg <= 5'(acc_sum - {1'b0, ACC_MOD});
      else
         acc_reg <= acc_sum[4:0];
   end

   // ----------------------------------------------------------------
   // frame bit counter, restarted by start of frame
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST || frm.sof)
         bit_cnt_reg <= 14'h0000; // RULE20
      else if (frame_end)
         bit_cnt_reg <= 14'h0000;
      else if (bit_tick)
         bit_cnt_reg <= bit_cnt_reg + 14'h0001; // RULE20
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         eof2_reg <= 1'b0;
      else
         eof2_reg <= eof2_hit; // RULE9
   end

   // ----------------------------------------------------------------
   // indicator blink, toggled every BLINK_LEN frames
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         blink_cnt_reg <= 9'h000;
         blink_reg <= 1'b0;
      end
      // one count per frame, even when sof trails the frame end
      else if (eof2_hit)
      begin
         if (blink_cnt_reg == 9'(BLINK_LEN - 1))
         begin
            blink_cnt_reg <= 9'h000;
            blink_reg <= !blink_reg; // RULE21
         end
         else
            blink_cnt_reg <= blink_cnt_reg + 9'h001;
      end
   end

   assign frm.eof2 = eof2_reg;
   assign frm.blink = blink_reg;
endmodule // hub_frame_timer

// File: tb/hub_status_reporting_assertions.sv
// Purpose: port checks of hub_status_reporting
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
module hub_status_reporting_checker
   import hub_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // requests and tokens
   input wire logic IN_TOKEN,
   input wire logic [3:0] TOKEN_EP,
   input wire logic REQ_VALID,
   input wire hub_pkg::req_e REQ_CODE,
   input wire logic [7:0] REQ_VALUE,
   // answers
   input wire logic CTRL_ACK,
   input wire logic CTRL_STALL,
   input wire logic EP1_NAK,
   input wire logic EP1_STALL,
   input wire logic EP1_DATA_VALID,
   input wire logic [7:0] EP1_DATA,
   // pins and views
   input wire logic OVERCURRENT_SENSE_INPUT_N,
   input wire logic PORT_POWER_ENABLE_OE,
   input wire logic [3:0] HUB_CONTROLLER_STATE,
   input wire logic [7:0] CHANGE_BITMAP,
   input wire logic OVERCURRENT_STATUS
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic ep1_in = IN_TOKEN && TOKEN_EP == EP_STATUS;
   wire logic ep1_ok = ep1_in && !HUB_CONTROLLER_STATE[ST_EP1_STALL];

   property p_ctrl_answer;
      REQ_VALID |=> CTRL_ACK != CTRL_STALL;
   endproperty
   a_ctrl_answer: assert property (p_ctrl_answer)
      else $error("control request without single answer");
   property p_other_stall;
      REQ_VALID && REQ_CODE == REQ_OTHER
         |=> CTRL_STALL && HUB_CONTROLLER_STATE[ST_EP0_STALL];
   endproperty
   a_other_stall: assert property (p_other_stall)
      else $error("unsupported request not stalled");
   property p_config;
      REQ_VALID && REQ_CODE == REQ_SET_CONFIG
         |=> HUB_CONTROLLER_STATE[ST_CONFIGURED] == ($past(REQ_VALUE) != 8'h00);
   endproperty
   a_config: assert property (p_config)
      else $error("configured bit does not follow request");
   property p_ep1_one;
      ep1_in |=> $onehot({EP1_NAK, EP1_STALL, EP1_DATA_VALID});
   endproperty
   a_ep1_one: assert property (p_ep1_one)
      else $error("endpoint 1 token without single answer");
   property p_ep1_nak;
      ep1_ok && CHANGE_BITMAP[4:0] == 5'h00 |=> EP1_NAK;
   endproperty
   a_ep1_nak: assert property (p_ep1_nak)
      else $error("empty bitmap not answered by nak");
   property p_ep1_data;
      ep1_ok && CHANGE_BITMAP[4:0] != 5'h00
         |=> EP1_DATA_VALID && EP1_DATA == $past(CHANGE_BITMAP);
   endproperty
   a_ep1_data: assert property (p_ep1_data)
      else $error("bitmap byte not returned");
   property p_reserved;
      CHANGE_BITMAP[7:5] == CHG_RESERVED;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bitmap bits not zero");
   property p_overcurrent;
      $fell(OVERCURRENT_SENSE_INPUT_N)
         |-> ##[2:4] (PORT_POWER_ENABLE_OE && OVERCURRENT_STATUS);
   endproperty
   a_overcurrent: assert property (p_overcurrent)
      else $error("overcurrent did not cut port power");
   c_data: cover property (ep1_in ##1 EP1_DATA_VALID);
   c_nak: cover property (ep1_in ##1 EP1_NAK);
   c_ovc: cover property ($fell(OVERCURRENT_SENSE_INPUT_N));
endmodule // hub_status_reporting_checker

bind hub_status_reporting hub_status_reporting_checker u_chk (
   .CLK(CLK), .RST(RST), .IN_TOKEN(IN_TOKEN), .TOKEN_EP(TOKEN_EP),
   .REQ_VALID(REQ_VALID), .REQ_CODE(REQ_CODE), .REQ_VALUE(REQ_VALUE),
   .CTRL_ACK(CTRL_ACK), .CTRL_STALL(CTRL_STALL), .EP1_NAK(EP1_NAK),
   .EP1_STALL(EP1_STALL), .EP1_DATA_VALID(EP1_DATA_VALID),
   .EP1_DATA(EP1_DATA),
   .OVERCURRENT_SENSE_INPUT_N(OVERCURRENT_SENSE_INPUT_N),
   .PORT_POWER_ENABLE_OE(PORT_POWER_ENABLE_OE),
   .HUB_CONTROLLER_STATE(HUB_CONTROLLER_STATE),
   .CHANGE_BITMAP(CHANGE_BITMAP), .OVERCURRENT_STATUS(OVERCURRENT_STATUS));

// File: tb/hub_host_model.sv
// Purpose: host side model issuing start-of-frame tokens
// Assumes: one frame is 1 ms, 20000 cycles at 20 MHz
// Notes: tokens stop while run is low
`timescale 1ns/1ps
module hub_host_model
#(
   parameter int FRAME_CLKS = 20000
)
(
   // clock and control
   input wire logic clk,
   input wire logic run,
   // token to the design
   output logic sof = 1'b0
);
   int cnt = 0;

   always @(negedge clk)
   begin
      sof <= run && cnt == 0;
      cnt <= (!run || cnt == FRAME_CLKS - 1) ? 0 : cnt + 1;
   end
endmodule // hub_host_model

// File: tb/hub_status_reporting_tb.sv
// Purpose: self-checking bench for hub_status_reporting
// Assumes: 20 MHz clock, default frame timer inside the design
// Notes: one full frame is waited out to see the bitmap sampled
`timescale 1ns/1ps
module hub_status_reporting_tb;
   import hub_pkg::*;
   logic clk, rst, sof, in_tok, req_v, ovc_n, susp, run;
   logic ack, stall, nak, ep1_stall, dv, pwr_o, pwr_oe, led_o, led_oe;
   logic osc, pll, overcurrent_sense_input;
   logic [3:0] ep, chg, state;
   logic [7:0] val, idx, data, bmp;
   logic [7:0] dt [5] = '{DT_DEVICE, DT_CONFIG, DT_INTERFACE, DT_ENDPOINT,
                          DT_HUB};
   req_e code;
   desc_sel_e dsel;
   int fails = 0;
   int compares = 0;

   hub_status_reporting u_hub_status_reporting (
      .CLK(clk), .RST(rst), .SOF_TOKEN(sof), .IN_TOKEN(in_tok),
      .TOKEN_EP(ep), .REQ_VALID(req_v), .REQ_CODE(code), .REQ_VALUE(val),
      .REQ_INDEX(idx), .CTRL_ACK(ack), .CTRL_STALL(stall), .DESC_SEL(dsel),
      .EP1_NAK(nak), .EP1_STALL(ep1_stall), .EP1_DATA_VALID(dv),
      .EP1_DATA(data), .PORT_CHANGE(chg), .OVERCURRENT_SENSE_INPUT_N(ovc_n),
      .PORT_POWER_ENABLE_O(pwr_o), .PORT_POWER_ENABLE_OE(pwr_oe),
      .STATUS_LED_O(led_o), .STATUS_LED_OE(led_oe), .SUSPEND(susp),
      .OSC_RUN(osc), .PLL_RUN(pll), .HUB_CONTROLLER_STATE(state),
      .CHANGE_BITMAP(bmp), .OVERCURRENT_STATUS(overcurrent_sense_input));
   hub_host_model u_hub_host_model (.clk(clk), .run(run), .sof(sof));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // request, then answer {ack,stall} and state one cycle later
   task automatic rq(input req_e c, input logic [7:0] v, i,
                     input logic [1:0] ea, input logic [3:0] es);
      @(negedge clk);
      req_v = 1'b1;
      code = c;
      val = v;
      idx = i;
      @(negedge clk);
      req_v = 1'b0;
      chk("ctrl", 8'(ea), 8'({ack, stall}));
      chk("state", 8'(es), 8'(state));
   endtask

   // token, then answer {nak,stall,data}
   task automatic tk(input logic [3:0] e, input logic [2:0] ea);
      @(negedge clk);
      in_tok = 1'b1;
      ep = e;
      @(negedge clk);
      in_tok = 1'b0;
      chk("ep1", 8'(ea), 8'({nak, ep1_stall, dv}));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      fails++;
      summarize();
   end

   initial
   begin
      rst = 1'b1;
      in_tok = 1'b0;
      req_v = 1'b0;
      ovc_n = 1'b1;
      susp = 1'b0;
      run = 1'b0;
      ep = 4'h0;
      chg = 4'h0;
      code = REQ_OTHER;
      val = 8'h00;
      idx = 8'h00;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk("state", 8'h00, 8'(state));
      chk("power_oe", 8'h01, 8'(pwr_oe));
      chk("led_oe", 8'h00, 8'(led_oe));
      chk("osc_pll", 8'h03, 8'({osc, pll}));
      chk("od_pins", 8'h00, 8'({pwr_o, led_o}));
      @(negedge clk);
      chg = 4'h2;
      @(negedge clk);
      chg = 4'h0;
      tk(4'h1, 3'h4);
      rq(REQ_SET_CONFIG, 8'h01, 8'h00, 2'h2, 4'h1);
      @(negedge clk);
      chk("led_oe", 8'h01, 8'(led_oe));
      for (int k = 0; k < 5; k++)
      begin
         rq(REQ_GET_DESC, dt[k], 8'h01, 2'h2, 4'h1);
         chk("desc", 8'(k + 1), 8'(dsel));
      end
      rq(REQ_GET_DESC, DT_ENDPOINT, 8'h00, 2'h1, 4'h5);
      rq(REQ_OTHER, 8'h00, 8'h00, 2'h1, 4'h5);
      rq(REQ_SET_WAKEUP, 8'h00, 8'h00, 2'h2, 4'h3);
      rq(REQ_CLR_WAKEUP, 8'h00, 8'h00, 2'h2, 4'h1);
      rq(REQ_SET_EP_HALT, 8'h00, 8'h01, 2'h2, 4'h9);
      tk(4'h1, 3'h2);
      rq(REQ_CLR_EP_HALT, 8'h00, 8'h01, 2'h2, 4'h1);
      tk(4'h2, 3'h0);
      rq(REQ_SET_PORT_POWER, 8'h00, 8'h01, 2'h2, 4'h1);
      chk("power_oe", 8'h00, 8'(pwr_oe));
      @(negedge clk);
      chg = 4'h2;
      ovc_n = 1'b0;
      @(negedge clk);
      chg = 4'h0;
      repeat (4) @(negedge clk);
      chk("power_oe", 8'h01, 8'(pwr_oe));
      chk("ovc", 8'h01, 8'(overcurrent_sense_input));
      ovc_n = 1'b1;
      chk("bitmap", 8'h00, bmp);
      run <= 1'b1;
      repeat (20020) @(negedge clk);
      chk("bitmap", 8'h05, bmp);
      chk("led_oe", 8'h00, 8'(led_oe));
      tk(4'h1, 3'h1);
      chk("data", 8'h05, data);
      tk(4'h1, 3'h1);
      rq(REQ_CLR_PORT_CHANGE, 8'h00, 8'h02, 2'h2, 4'h1);
      chk("bitmap", 8'h01, bmp);
      rq(REQ_CLR_HUB_CHANGE, 8'h00, 8'h00, 2'h2, 4'h1);
      tk(4'h1, 3'h4);
      rq(REQ_CLR_PORT_POWER, 8'h00, 8'h01, 2'h2, 4'h1);
      @(negedge clk);
      chk("led_oe", 8'h01, 8'(led_oe));
      susp = 1'b1;
      repeat (2) @(negedge clk);
      chk("osc", 8'h00, 8'({osc, pll}));
      susp = 1'b0;
      summarize();
   end
endmodule // hub_status_reporting_tb
